// ==== hw/lbfc_pkg.sv ====
// Package for the local bus frame control block.
// Assumes one board clock; all neighbours and access sources share it.
package lbfc_pkg;

  // Register byte addresses on the AXI4-Lite port.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ERROR = 4'h4;
  localparam logic [3:0] ADDR_FIFO = 4'h8;

  // Control register field positions.
  localparam int CTRL_LOOP = 26;
  localparam int CTRL_SWIRQ = 25;
  localparam int CTRL_ERR_EN = 24;
  localparam int CTRL_RDY_EN = 23;
  localparam int CTRL_TXD_EN = 22;
  localparam int CTRL_RX_EN = 21;
  localparam int CTRL_LAST_STB = 20;
  localparam int CTRL_LOST = 19;
  localparam int CTRL_SPACE = 18;
  localparam int CTRL_SENT = 17;
  localparam int CTRL_RXF = 16;
  localparam int CTRL_LEN_LO = 8;
  localparam int CTRL_LINK = 7;
  localparam int CTRL_END = 6;
  localparam int CTRL_BUS_EN = 4;
  // Bits software may store in the control register.
  localparam logic [31:0] CTRL_RW_MASK = 32'h07E0_00DF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Error register field positions.
  localparam int ERR_LOST_LO = 20;
  localparam int ERR_DSP_BC = 19;
  localparam int ERR_DSP_MIX = 18;
  localparam int ERR_DSP_MASK_LO = 10;
  localparam int ERR_HOST_BC = 9;
  localparam int ERR_HOST_MIX = 8;
  localparam int ERR_HOST_MASK_LO = 0;

  // Frame header layout: source id in the low nibble, destination above.
  localparam int HDR_SRC_LO = 0;
  localparam int HDR_DST_LO = 4;
  localparam logic [3:0] MAX_NODE_ID = 4'hC;

  // Outgoing buffer sizing and the room kept free for one whole frame.
  localparam int TX_AW = 6;
  localparam logic [TX_AW:0] TX_DEPTH = 7'h40;
  localparam logic [TX_AW:0] TX_FRAME_ROOM = 7'h10;
  localparam int RX_AW = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [31:0] data;
  } lbfc_word_t;

  typedef struct packed {
    logic valid;
    logic read;
    logic bcast;
    logic [7:0] high_speed_card;
    logic [7:0] standard_card;
  } lbfc_acc_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HDR = 2'b01,
    TX_BODY = 2'b10
  } lbfc_tx_state_t;

endpackage : lbfc_pkg

// ==== hw/lbfc_top.sv ====
// Local bus frame control: registers, frame buffers, chain link and the
// function-card access error capture.
// Assumes left/right chain neighbours, the DSP link port and the access
// sources run on aclk; register access is AXI4-Lite.
// What this block does
// [R1] Loop-back returns link-port frames to the DSP.
// [R2] Software interrupt bit drives DSP interrupt directly.
// [R3] Lost-frame error interrupts only when enabled.
// [R4] Transmit space flag interrupts only when enabled.
// [R5] All-sent flag interrupts only when enabled.
// [R6] Frame-received flag interrupts only when enabled.
// [R7] Frame-complete write of 1 starts sending.
// [R8] Sticky lost-frame flag when buffer busy; read-clear.
// [R9] Transmit space flag: one from reset, room.
// [R10] All-sent flag: empty buffer; cleared by port write.
// [R11] Frame-received flag; cleared by first port read.
// [R12] Received length in words, byte field.
// [R13] Link-port select moves frames off the port.
// [R14] Chain end stops right sends, tri-states drivers.
// [R15] Bus enable gates logic and buffers.
// [R16] Node id as header source and destination match.
// [R17] Read-clear lost-source mask, bit 0 is id 1.
// [R18] DSP broadcast read: no access, invalid, flag.
// [R19] DSP mixed-speed access: no access, flag.
// [R20] DSP card mask frozen until flag read.
// [R21] Host broadcast read: no access, invalid, flag.
// [R22] Host mixed access blocked, flagged, mask captured.
// [R23] Port writes feed outgoing, reads drain incoming.
// [R24] Set wins over read-clear in same cycle.
//
// Implementation choices: the address map and the AXI4-Lite register port.
module lbfc_top
  import lbfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lbfc_word_t lb_left_in,
  output logic lb_left_ready,
  output lbfc_word_t lb_right_out,
  output logic lb_right_oe,
  input wire lbfc_word_t link_in,
  output logic link_in_ready,
  output lbfc_word_t link_out,
  input wire lbfc_acc_t dsp_acc,
  output logic dsp_card_go,
  output logic dsp_data_invalid,
  input wire lbfc_acc_t host_acc,
  output logic host_card_go,
  output logic host_data_invalid,
  output logic dsp_interrupt_line
);

  function automatic logic is_mixed(input lbfc_acc_t a);
    is_mixed = (|a.high_speed_card) && (|a.standard_card);
  endfunction : is_mixed

  function automatic logic [11:0] src_bit(input logic [3:0] id);
    src_bit = 12'h000;
    if (id != 4'h0 && id <= MAX_NODE_ID) begin
      src_bit[id - 4'h1] = 1'b1;
    end
  endfunction : src_bit

  logic [31:0] ctrl;
  logic lost_flag;
  logic sent_flag;
  logic rxf_flag;
  logic [7:0] rx_len;
  logic [11:0] lost_mask;
  logic dsp_bc, dsp_mix, host_bc, host_mix;
  logic [7:0] dsp_mask, host_mask;

  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do, rd_do;
  logic [31:0] strb_mask;

  logic [31:0] tx_mem [0:(1 << TX_AW) - 1];
  logic tx_end [0:(1 << TX_AW) - 1];
  logic [TX_AW:0] tx_wp, tx_rp, tx_count;
  logic [TX_AW:0] tx_frames;
  lbfc_tx_state_t tx_state;
  logic [31:0] rx_mem [0:(1 << RX_AW) - 1];
  logic [RX_AW-1:0] rx_wp, rx_rp;
  logic rx_pending, rx_capture, rx_drop, fwd_busy;

  logic bus_en, link_mode, loop_en, chain_end;
  logic [3:0] node_id;
  logic port_wr, port_rd, ctrl_rd, err_rd, stb_done;
  logic tx_push, tx_pop, tx_start;
  logic [31:0] tx_push_data;
  logic tx_push_last, frame_mark;
  logic lb_take, lb_mine, rx_pop, lost_ev;
  logic [TX_AW:0] tx_last_idx;

  assign bus_en = ctrl[CTRL_BUS_EN]; // R15
  assign link_mode = ctrl[CTRL_LINK];
  assign loop_en = ctrl[CTRL_LOOP];
  assign chain_end = ctrl[CTRL_END];
  assign node_id = ctrl[3:0];
  assign tx_count = tx_wp - tx_rp;
  assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}};

  // AXI4-Lite write: address and data are held in either order.
  assign wr_do = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= wr_do || (s_axi_awready && !s_axi_awvalid);
      s_axi_wready <= wr_do || (s_axi_wready && !s_axi_wvalid);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_ERROR ||
                        aw_addr == ADDR_FIFO) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: data is captured the edge the address is taken.
  assign rd_do = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (rd_do) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: begin
          s_axi_rdata <= (ctrl & CTRL_RW_MASK & ~32'h0000_0020)
            | ({31'h0, lost_flag} << CTRL_LOST)
            | ({31'h0, tx_count <= TX_DEPTH - TX_FRAME_ROOM} << CTRL_SPACE)
            | ({31'h0, sent_flag} << CTRL_SENT)
            | ({31'h0, rxf_flag} << CTRL_RXF)
            | ({24'h0, rx_len} << CTRL_LEN_LO); // R9 R12
        end
        ADDR_ERROR: begin
          s_axi_rdata <= {lost_mask, dsp_bc, dsp_mix, dsp_mask,
                          host_bc, host_mix, host_mask};
        end
        ADDR_FIFO: begin
          s_axi_rdata <= (port_rd && rx_pending) ? rx_mem[rx_rp]
                                                 : 32'h0000_0000;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign ctrl_rd = rd_do && s_axi_araddr == ADDR_CTRL;
  assign err_rd = rd_do && s_axi_araddr == ADDR_ERROR;
  assign port_rd = rd_do && s_axi_araddr == ADDR_FIFO && !link_mode; // R13 R23
  assign port_wr = wr_do && aw_addr == ADDR_FIFO && !link_mode; // R13 R23
  assign stb_done = wr_do && aw_addr == ADDR_CTRL && w_strb[2]
                    && w_data[CTRL_LAST_STB]; // R7

  // Control bits; the frame-complete bit is a strobe and is not stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_do && aw_addr == ADDR_CTRL) begin
      ctrl <= (ctrl & ~(strb_mask & CTRL_RW_MASK))
              | (w_data & strb_mask & CTRL_RW_MASK);
    end
  end

  // Outgoing buffer writer: port words or link-port words.
  assign tx_push = bus_en && (port_wr || (link_mode && !loop_en
                   && link_in.valid && link_in_ready)); // R13 R23
  assign tx_push_data = port_wr ? w_data : link_in.data;
  assign tx_push_last = !port_wr && link_in.last;
  assign tx_last_idx = tx_wp - 7'h01;
  assign frame_mark = bus_en && stb_done && tx_count != 7'h00
                      && !tx_end[tx_last_idx[TX_AW-1:0]]; // R7
  assign tx_pop = tx_state == TX_BODY;
  assign tx_start = tx_state == TX_IDLE && tx_frames != 7'h00 && bus_en
                    && !chain_end && !fwd_busy && !lb_left_in.valid; // R14

  always_ff @(posedge aclk) begin
    if (tx_push && tx_count != TX_DEPTH) begin
      tx_mem[tx_wp[TX_AW-1:0]] <= tx_push_data;
      tx_end[tx_wp[TX_AW-1:0]] <= tx_push_last;
    end else if (frame_mark) begin
      tx_end[tx_last_idx[TX_AW-1:0]] <= 1'b1; // R7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_wp <= 7'h00;
      tx_rp <= 7'h00;
      tx_frames <= 7'h00;
      tx_state <= TX_IDLE;
    end else begin
      if (tx_push && tx_count != TX_DEPTH) begin
        tx_wp <= tx_wp + 7'h01;
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + 7'h01;
      end
      tx_frames <= tx_frames
        + {6'h00, (tx_push && tx_push_last) || frame_mark}
        - {6'h00, tx_pop && tx_end[tx_rp[TX_AW-1:0]]};
      case (tx_state)
        TX_IDLE: if (tx_start) tx_state <= TX_HDR;
        TX_HDR: tx_state <= TX_BODY;
        TX_BODY: if (tx_end[tx_rp[TX_AW-1:0]]) tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Chain receive: own frames are stored, others pass to the right.
  assign lb_take = bus_en && lb_left_in.valid && lb_left_ready; // R15
  assign lb_mine = lb_left_in.data[HDR_DST_LO +: 4] == node_id; // R16
  assign lost_ev = lb_take && lb_left_in.first && lb_mine
                   && (rx_pending || rx_capture); // R8
  assign rx_pop = rx_pending && (port_rd
                  || (link_mode && !loop_en)); // R13 R23

  always_ff @(posedge aclk) begin
    if (lb_take && !lb_left_in.first && rx_capture) begin
      rx_mem[rx_wp] <= lb_left_in.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_capture <= 1'b0;
      rx_drop <= 1'b0;
      fwd_busy <= 1'b0;
      rx_pending <= 1'b0;
      rx_wp <= 8'h00;
      rx_rp <= 8'h00;
      rx_len <= 8'h00;
      rxf_flag <= 1'b0;
    end else begin
      if (rx_pop) begin
        rx_rp <= rx_rp + 8'h01;
        if (rx_rp + 8'h01 == rx_len) begin
          rx_pending <= 1'b0;
        end
      end
      if (port_rd) begin
        rxf_flag <= 1'b0; // R11
      end
      if (lb_take) begin
        if (lb_left_in.first) begin
          rx_capture <= lb_mine && !lost_ev && !lb_left_in.last;
          rx_drop <= lost_ev && !lb_left_in.last; // R8
          fwd_busy <= !lb_mine && !lb_left_in.last;
          rx_wp <= 8'h00;
          if (lb_mine && !lost_ev && lb_left_in.last) begin
            rxf_flag <= 1'b1;
            rx_len <= 8'h00;
          end
        end else if (rx_capture) begin
          rx_wp <= rx_wp + 8'h01;
          if (lb_left_in.last) begin
            rx_capture <= 1'b0;
            rx_pending <= 1'b1;
            rx_rp <= 8'h00;
            rxf_flag <= 1'b1; // R11
            rx_len <= rx_wp + 8'h01; // R12
          end
        end else if (lb_left_in.last) begin
          rx_drop <= 1'b0;
          fwd_busy <= 1'b0;
        end
      end
    end
  end

  // Right-hand output: forwarded traffic or own frames.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lb_right_out <= '0;
      lb_right_oe <= 1'b0;
      lb_left_ready <= 1'b0;
    end else begin
      lb_right_oe <= bus_en && !chain_end; // R14 R15
      lb_left_ready <= bus_en && !tx_start && tx_state == TX_IDLE;
      lb_right_out <= '0;
      if (tx_state == TX_HDR) begin
        lb_right_out.valid <= 1'b1;
        lb_right_out.first <= 1'b1;
        lb_right_out.data <= {24'h00_0000, 4'h0, node_id}; // R16
      end else if (tx_state == TX_BODY) begin
        lb_right_out.valid <= 1'b1;
        lb_right_out.last <= tx_end[tx_rp[TX_AW-1:0]];
        lb_right_out.data <= tx_mem[tx_rp[TX_AW-1:0]];
      end else if (lb_take && !chain_end && !rx_capture && !rx_drop
                   && !(lb_left_in.first && lb_mine)) begin
        lb_right_out <= lb_left_in; // R14
      end
    end
  end

  // Link port to the DSP: received frames, or the loop-back echo.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_out <= '0;
      link_in_ready <= 1'b0;
    end else begin
      link_in_ready <= bus_en && link_mode
        && (loop_en || tx_count < TX_DEPTH - 7'h01);
      link_out <= '0;
      if (loop_en && link_mode) begin
        link_out <= link_in_ready ? link_in : '0; // R1
      end else if (rx_pop && !port_rd) begin
        link_out.valid <= 1'b1;
        link_out.first <= rx_rp == 8'h00;
        link_out.last <= rx_rp + 8'h01 == rx_len;
        link_out.data <= rx_mem[rx_rp]; // R13
      end
    end
  end

  // All-sent flag comes up only once the last word has left.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sent_flag <= 1'b0;
    end else if (port_wr) begin
      sent_flag <= 1'b0; // R10
    end else if (tx_pop && tx_count == 7'h01) begin
      sent_flag <= 1'b1; // R10
    end
  end

  // Read-clear flags; an event in the reading cycle keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lost_flag <= 1'b0;
      lost_mask <= 12'h000;
      dsp_bc <= 1'b0;
      dsp_mix <= 1'b0;
      dsp_mask <= 8'h00;
      host_bc <= 1'b0;
      host_mix <= 1'b0;
      host_mask <= 8'h00;
    end else begin
      lost_flag <= (lost_flag && !ctrl_rd) || lost_ev; // R8 R24
      lost_mask <= (err_rd ? 12'h000 : lost_mask)
        | (lost_ev ? src_bit(lb_left_in.data[HDR_SRC_LO +: 4])
                   : 12'h000); // R17 R24
      dsp_bc <= (dsp_bc && !err_rd)
        || (dsp_acc.valid && dsp_acc.read && dsp_acc.bcast); // R18 R24
      host_bc <= (host_bc && !err_rd)
        || (host_acc.valid && host_acc.read && host_acc.bcast); // R21 R24
      dsp_mix <= (dsp_mix && !err_rd)
        || (dsp_acc.valid && is_mixed(dsp_acc)); // R19 R24
      host_mix <= (host_mix && !err_rd)
        || (host_acc.valid && is_mixed(host_acc)); // R22 R24
      // The mask keeps the first fault so the cause is not overwritten.
      if (dsp_acc.valid && is_mixed(dsp_acc) && (!dsp_mix || err_rd)) begin
        dsp_mask <= dsp_acc.high_speed_card | dsp_acc.standard_card; // R20
      end
      if (host_acc.valid && is_mixed(host_acc)
          && (!host_mix || err_rd)) begin
        host_mask <= host_acc.high_speed_card
                     | host_acc.standard_card; // R22
      end
    end
  end

  // Card access gating: faulty requests never reach the cards.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsp_card_go <= 1'b0;
      dsp_data_invalid <= 1'b0;
      host_card_go <= 1'b0;
      host_data_invalid <= 1'b0;
    end else begin
      dsp_card_go <= dsp_acc.valid && !is_mixed(dsp_acc)
        && !(dsp_acc.read && dsp_acc.bcast); // R18 R19
      dsp_data_invalid <= dsp_acc.valid && dsp_acc.read
        && (dsp_acc.bcast || is_mixed(dsp_acc)); // R18 R19
      host_card_go <= host_acc.valid && !is_mixed(host_acc)
        && !(host_acc.read && host_acc.bcast); // R21 R22
      host_data_invalid <= host_acc.valid && host_acc.read
        && (host_acc.bcast || is_mixed(host_acc)); // R21 R22
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsp_interrupt_line <= 1'b0;
    end else begin
      dsp_interrupt_line <= ctrl[CTRL_SWIRQ] // R2
        || (ctrl[CTRL_ERR_EN] && lost_flag) // R3
        || (ctrl[CTRL_RDY_EN]
            && tx_count <= TX_DEPTH - TX_FRAME_ROOM) // R4
        || (ctrl[CTRL_TXD_EN] && sent_flag) // R5
        || (ctrl[CTRL_RX_EN] && rxf_flag); // R6
    end
  end

endmodule : lbfc_top

// ==== verification/lbfc_nbr_model.sv ====
// Left neighbour board model: sends whole frames into the chain input.
// Assumes the block takes a word at an edge where valid and ready are high.
module lbfc_nbr_model
  import lbfc_pkg::*;
(
  input wire logic aclk,
  input wire logic lb_left_ready,
  output lbfc_word_t lb_left_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial lb_left_in = '0;

  task automatic send(input logic [3:0] dst, input logic [3:0] src,
                      input logic [31:0] w[$]);
    for (int i = 0; i <= w.size(); i++) begin
      lb_left_in <= '{1'b1, i == 0, i == w.size(),
                      i == 0 ? {24'h0, dst, src} : w[i - 1]};
      do @(posedge aclk); while (lb_left_ready !== 1'b1);
    end
    // Idle data is inverted so a stale word can never pass as fresh.
    lb_left_in <= '{1'b0, 1'b0, 1'b0, ~lb_left_in.data};
  endtask : send
endmodule : lbfc_nbr_model

// ==== verification/lbfc_asserts.sv ====
// Checker for the local bus frame control block, bound to its top.
// Assumes one-cycle access requests and one clock domain.
module lbfc_asserts
  import lbfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire lbfc_acc_t dsp_acc,
  input wire logic dsp_card_go,
  input wire logic dsp_data_invalid,
  input wire lbfc_acc_t host_acc,
  input wire logic host_card_go,
  input wire logic host_data_invalid,
  input wire lbfc_word_t lb_right_out,
  input wire logic lb_right_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic dbr, dmx, hbr, hmx;
  assign dbr = dsp_acc.valid & dsp_acc.read & dsp_acc.bcast;
  assign dmx = dsp_acc.valid & (|dsp_acc.high_speed_card)
    & (|dsp_acc.standard_card);
  assign hbr = host_acc.valid & host_acc.read & host_acc.bcast;
  assign hmx = host_acc.valid & (|host_acc.high_speed_card)
    & (|host_acc.standard_card);

  a_dsp_bcast_block: assert property (
    dbr |=> !dsp_card_go && dsp_data_invalid)
    else $error("dsp broadcast read not blocked");
  a_dsp_mix_block: assert property (
    dmx |=> !dsp_card_go) else $error("dsp mixed access went out");
  a_dsp_mix_read: assert property (
    dmx && dsp_acc.read |=> dsp_data_invalid)
    else $error("dsp mixed read not invalid");
  a_dsp_go_cause: assert property (
    dsp_card_go |-> $past(dsp_acc.valid) && !$past(dbr) && !$past(dmx))
    else $error("dsp card access without good request");
  a_host_bcast_block: assert property (
    hbr |=> !host_card_go && host_data_invalid)
    else $error("host broadcast read not blocked");
  a_host_mix_block: assert property (
    hmx |=> !host_card_go) else $error("host mixed access went out");
  a_host_go_cause: assert property (
    host_card_go |-> $past(host_acc.valid) && !$past(hbr) && !$past(hmx))
    else $error("host card access without good request");
  a_chain_end_quiet: assert property (
    !lb_right_oe |-> !lb_right_out.valid)
    else $error("right word sent while drivers off");
endmodule : lbfc_asserts

bind lbfc_top lbfc_asserts chk_u (.aclk, .aresetn, .dsp_acc, .dsp_card_go,
  .dsp_data_invalid, .host_acc, .host_card_go, .host_data_invalid,
  .lb_right_out, .lb_right_oe);

// ==== verification/lbfc_bench.sv ====
// Self-checking bench for the local bus frame control block.
// Assumes lbfc_top, its checker and the neighbour model are compiled first.
module lbfc_bench
  import lbfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rv;
  lbfc_word_t lb_left_in, lb_right_out, link_out;
  lbfc_word_t link_in = '0;
  logic lb_left_ready, lb_right_oe, link_in_ready, dsp_interrupt_line;
  lbfc_acc_t dsp_acc = '0, host_acc = '0;
  logic dsp_card_go, dsp_data_invalid, host_card_go, host_data_invalid;
  lbfc_word_t outq[$];
  int failures = 0, check_count = 0, cycles = 0;
  integer seed = 32'h943f_249c;

  lbfc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lb_left_in,
    .lb_left_ready, .lb_right_out, .lb_right_oe, .link_in, .link_in_ready,
    .link_out, .dsp_acc, .dsp_card_go, .dsp_data_invalid, .host_acc,
    .host_card_go, .host_data_invalid, .dsp_interrupt_line);
  lbfc_nbr_model nbr_u (.aclk, .lb_left_ready, .lb_left_in);

  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (lb_right_out.valid) outq.push_back(lb_right_out);
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  task automatic rc(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, rv & m);
  endtask : rc

  task automatic tick();
    repeat (2) @(posedge aclk);
  endtask : tick

  task automatic acc(input int h, input lbfc_acc_t a);
    @(posedge aclk);
    if (h == 1) host_acc <= a;
    else dsp_acc <= a;
    @(posedge aclk);
    host_acc <= '0;
    dsp_acc <= '0;
  endtask : acc

  initial begin
    logic [31:0] pay[$];
    logic [31:0] d;
    logic [31:0] e;
    logic [7:0] hs;
    logic [7:0] sd;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ADDR_CTRL, '1, 32'h0004_0000, "ctrl reset");
    rc(ADDR_ERROR, '1, 32'h0000_0000, "error reset");
    rd(4'hC);
    chk("unmapped resp", RESP_SLVERR, resp);
    d = $random(seed) & CTRL_RW_MASK;
    wr(ADDR_CTRL, d);
    rc(ADDR_CTRL, CTRL_RW_MASK, d, "ctrl rw");
    wr(ADDR_CTRL, 32'h0200_0000);
    tick();
    chk("software_interrupt on", 1'b1, dsp_interrupt_line);
    wr(ADDR_CTRL, 32'h0000_0000);
    tick();
    chk("software_interrupt off", 1'b0, dsp_interrupt_line);
    wr(ADDR_CTRL, 32'h0080_0000);
    tick();
    chk("space irq", 1'b1, dsp_interrupt_line);
    $display("test control done");
    wr(ADDR_CTRL, 32'h0040_0013);
    repeat (4) begin
      d = $random(seed);
      pay.push_back(d);
      wr(ADDR_FIFO, d);
    end
    rc(ADDR_CTRL, 32'h0002_0000, 32'h0000_0000, "sent clr");
    // Strobe on byte 2 only; the done enable in that byte is written again.
    wr(ADDR_CTRL, 32'h0050_0000, 4'h4);
    for (int n = 0; n < 200 && !(outq.size() > 0 && outq[$].last); n++)
      @(posedge aclk);
    chk("hdr src", 4'h3, outq[0].data[3:0]);
    chk("hdr first", 1'b1, outq[0].first);
    chk("tail", pay[$], outq[$].data);
    chk("words", 5, outq.size());
    rc(ADDR_CTRL, 32'h0002_0000, 32'h0002_0000, "sent");
    chk("done irq", 1'b1, dsp_interrupt_line);
    chk("right oe", 1'b1, lb_right_oe);
    wr(ADDR_CTRL, 32'h0000_0053);
    tick();
    chk("end oe", 1'b0, lb_right_oe);
    $display("test transmit done");
    wr(ADDR_CTRL, 32'h0020_0013);
    pay = {};
    repeat (3) pay.push_back($random(seed));
    nbr_u.send(4'h3, 4'h5, pay);
    rv = '0;
    for (int n = 0; n < 20 && rv[CTRL_RXF] !== 1'b1; n++) rd(ADDR_CTRL);
    rc(ADDR_CTRL, 32'h0001_FF00, 32'h0001_0300, "rx len");
    chk("rx irq", 1'b1, dsp_interrupt_line);
    nbr_u.send(4'h3, 4'h5, pay);
    rc(ADDR_ERROR, 32'hFFF0_0000, 32'h0100_0000, "lost mask");
    rc(ADDR_ERROR, 32'hFFF0_0000, 32'h0000_0000, "mask clr");
    wr(ADDR_CTRL, 32'h0100_0013);
    tick();
    chk("err irq", 1'b1, dsp_interrupt_line);
    rc(ADDR_CTRL, 32'h0008_0000, 32'h0008_0000, "lost");
    rc(ADDR_CTRL, 32'h0008_0000, 32'h0000_0000, "lost clr");
    foreach (pay[i]) begin
      rc(ADDR_FIFO, '1, pay[i], "rx word");
      rc(ADDR_CTRL, 32'h0001_0000, 32'h0000_0000, "rx clr");
    end
    wr(ADDR_CTRL, 32'h0000_0000);
    tick();
    chk("off oe", 1'b0, lb_right_oe);
    wr(ADDR_CTRL, 32'h0400_0090);
    tick();
    d = $random(seed);
    link_in <= '{1'b1, 1'b1, 1'b1, d};
    @(posedge aclk);
    link_in <= '0;
    @(posedge aclk);
    chk("loop echo", d, link_out.data);
    chk("loop valid", 1'b1, link_out.valid);
    $display("test receive done");
    for (int h = 0; h < 2; h++) begin
      d = $random(seed);
      hs = {4'h0, d[3:0] | 4'h1};
      sd = {d[7:4] | 4'h8, 4'h0};
      acc(h, '{1'b1, d[8], 1'b0, hs, sd});
      acc(h, '{1'b1, 1'b0, 1'b0, 8'h02, 8'h04});
      acc(h, '{1'b1, 1'b1, 1'b1, 8'h01, 8'h00});
      acc(h, '{1'b1, d[9], 1'b0, 8'h01, 8'h00});
      e = h ? 32'h0000_0300 | (hs | sd) : 32'h000C_0000 | ((hs | sd) << 10);
      d = h ? 32'h0000_03FF : 32'h000F_FC00;
      rc(ADDR_ERROR, d, e, "acc err");
      rc(ADDR_ERROR, 32'h000C_0300, 32'h0000_0000, "acc clr");
    end
    $display("test access done");
    final_report();
  end
endmodule : lbfc_bench
